/* File: rtl/hbic_ctrl.sv */
// Purpose: control and status bank of the graphics host bus interface
// Assumes: single clock; register port strobes are one-cycle pulses
// Notes: clock enable low freezes every flip-flop
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module hbic_ctrl #(
  parameter int unsigned COH_TIMEOUT = 67108864,
  parameter int unsigned DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [hbic_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic mst_rd_req_i,
  input wire logic mst_rd_cpl_i,
  output logic mst_rd_grant_o,
  output logic mst_rd_abort_o,
  output logic [DATA_W-1:0] mst_rd_data_o,
  input wire logic msi_event_i,
  output logic msi_send_o,
  input wire logic [hbic_pkg::N_SYNC-1:0] xdom_i,
  output logic [hbic_pkg::N_SYNC-1:0] xdom_o,
  input wire logic [1:0] f0_dstate_i,
  input wire logic [1:0] f1_dstate_i,
  output logic [1:0] eff_dstate_o,
  output logic dual_master_en_o,
  input wire logic backbone_busy_i,
  output logic backbone_busy_o,
  input wire logic coh_wait_i,
  output logic coh_wait_o,
  input wire logic coh_lock_i,
  output logic coh_lock_o,
  output logic [4:0] coh_check_en_o,
  output logic imm_decode_pm_o,
  input wire logic pm_busy_i,
  output logic pm_busy_o,
  output logic io_en_o,
  output logic mem_en_o,
  output logic bm_en_o,
  output logic int_en_o,
  input wire logic hdp_wr_i,
  output logic hdp_rd_allow_o,
  input wire logic mem_active_i,
  output logic mclk_en_o,
  output logic gfx_mc_master_en_o,
  output logic aud_mc_master_en_o,
  input wire logic gfx_int_i,
  input wire logic aud_int_i,
  output logic [3*hbic_pkg::N_WM-1:0] fifo_slots_o,
  output logic register_read_wait_o,
  output logic multi_read_allow_o,
  output logic nonposted_wait_skip_o,
  output logic wide_write_en_o,
  output logic [1:0] perf0_clk_sel_o,
  output logic [1:0] perf1_clk_sel_o
);
  localparam int unsigned COH_W = $clog2(COH_TIMEOUT + 1);
  localparam logic [COH_W-1:0] COH_LIMIT = COH_W'(COH_TIMEOUT);
  localparam logic [5:0] BUSY_LIMIT = 6'(hbic_pkg::BUSY_IGN_CYC);
  localparam logic [2:0] RD_MULTI = 3'(hbic_pkg::MAX_RD_MULTI);
  localparam logic [2:0] RD_ONE = 3'(hbic_pkg::MAX_RD_ONE);

  logic [31:0] bus_control_main;
  logic [31:0] bus_control_secondary;
  logic [31:0] target_side_control;
  logic msi_armed;
  logic [2:0] rd_out;
  logic [5:0] busy_cnt;
  logic [COH_W-1:0] wait_cnt;
  logic [COH_W-1:0] lock_cnt;
  logic [7:0] dly_cnt;
  logic [7:0] idle_cnt;
  logic [hbic_pkg::N_SYNC-1:0] sync_q;
  logic [1:0] next_dstate;
  logic low_power;
  logic wr_main;
  logic [2:0] rd_limit;
  logic rd_take;
  logic [2:0] next_rd_out;

  assign wr_main = reg_wr_i && (reg_addr_i == hbic_pkg::OFF_BUS_MAIN);

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus_control_main <= hbic_pkg::RST_BUS_MAIN;
      bus_control_secondary <= hbic_pkg::RST_BUS_SEC;
      target_side_control <= hbic_pkg::RST_TGT;
    end else if (ce_i && reg_wr_i) begin
      // spare bits are kept as written
      case (reg_addr_i)
        hbic_pkg::OFF_BUS_MAIN: bus_control_main <= reg_wdata_i & ~hbic_pkg::RO_BUS_MAIN;
        hbic_pkg::OFF_BUS_SEC: bus_control_secondary <= reg_wdata_i & ~hbic_pkg::RO_BUS_SEC;
        hbic_pkg::OFF_TGT: target_side_control <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // status and power-derived bits are merged at read time only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          hbic_pkg::OFF_BUS_MAIN: begin
            reg_rdata_o <= bus_control_main;
            reg_rdata_o[hbic_pkg::B_MST_BUSY] <= (rd_out != 3'h0);
            if (!bus_control_main[hbic_pkg::B_IMM_EN_RB]) begin
              reg_rdata_o[hbic_pkg::B_IMM_EN] <= low_power;
            end
            if (!bus_control_main[hbic_pkg::B_IMM_DIS_RB]) begin
              reg_rdata_o[hbic_pkg::B_IMM_DIS] <= low_power;
            end
          end
          hbic_pkg::OFF_BUS_SEC: begin
            reg_rdata_o <= bus_control_secondary;
            reg_rdata_o[hbic_pkg::S_GFX_INT] <= gfx_int_i;
            reg_rdata_o[hbic_pkg::S_AUD_INT] <= aud_int_i;
          end
          hbic_pkg::OFF_TGT: reg_rdata_o <= target_side_control;
          default: reg_rdata_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // message interrupt re-arm
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      msi_armed <= 1'b1;
      msi_send_o <= 1'b0;
    end else if (ce_i) begin
      msi_send_o <= msi_event_i && msi_armed;
      // re-arm wins over a send in the same cycle
      if (wr_main && !bus_control_main[hbic_pkg::B_REARM] && reg_wdata_i[hbic_pkg::B_REARM]) begin
        msi_armed <= 1'b1;
      end else if (msi_event_i && msi_armed) begin
        msi_armed <= 1'b0;
      end
    end
  end

  AST_REARM_SETS_ARMED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && wr_main && !bus_control_main[hbic_pkg::B_REARM] && reg_wdata_i[hbic_pkg::B_REARM]
    |=> msi_armed) else $error("re-arm sequence did not arm message interrupt");

  ////////////////////////////////////////////////////////////////////////////////
  // master read path
  assign rd_limit = bus_control_main[hbic_pkg::B_SINGLE_RD] ? RD_ONE : RD_MULTI;
  assign rd_take = mst_rd_req_i && !bus_control_main[hbic_pkg::B_GFX_BLOCK] && (rd_out < rd_limit);

  always_comb begin
    next_rd_out = rd_out;
    if (rd_take && !(mst_rd_cpl_i && rd_out != 3'h0)) begin
      next_rd_out = rd_out + 3'h1;
    end else if (!rd_take && mst_rd_cpl_i && rd_out != 3'h0) begin
      next_rd_out = rd_out - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_out <= 3'h0;
      mst_rd_grant_o <= 1'b0;
      mst_rd_abort_o <= 1'b0;
      mst_rd_data_o <= '0;
    end else if (ce_i) begin
      rd_out <= next_rd_out;
      mst_rd_grant_o <= rd_take;
      mst_rd_abort_o <= mst_rd_req_i && bus_control_main[hbic_pkg::B_GFX_BLOCK];
      mst_rd_data_o <= (mst_rd_req_i && bus_control_main[hbic_pkg::B_GFX_BLOCK]) ? '1 : '0;
    end
  end

  AST_BLOCK_ABORTS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && mst_rd_req_i && bus_control_main[hbic_pkg::B_GFX_BLOCK]
    |=> mst_rd_abort_o && !mst_rd_grant_o && (mst_rd_data_o == '1))
    else $error("blocked master read not aborted with all-ones");
  AST_READ_LIMIT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_out <= (bus_control_main[hbic_pkg::B_SINGLE_RD] ? RD_ONE : RD_MULTI)
    || $past(rd_out) >= rd_out) else $error("outstanding reads above limit");

  ////////////////////////////////////////////////////////////////////////////////
  // crossings for the five xdom_i inputs, depth picked per bit from bus_control_main
  for (genvar g = 0; g < hbic_pkg::N_SYNC; g++) begin : g_sync
    hbic_sync u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .dbl_i(bus_control_main[hbic_pkg::B_SYNC_LO + g]),
      .d_i(xdom_i[g]),
      .q_o(sync_q[g])
    );
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      xdom_o <= '0;
    end else if (ce_i) begin
      xdom_o <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state selection and gating
  always_comb begin
    if (bus_control_main[hbic_pkg::B_MF_PICK]) begin
      next_dstate = (f0_dstate_i < f1_dstate_i) ? f0_dstate_i : f1_dstate_i;
    end else begin
      next_dstate = (f0_dstate_i > f1_dstate_i) ? f0_dstate_i : f1_dstate_i;
    end
  end
  assign low_power = (eff_dstate_o != hbic_pkg::DSTATE_D0);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      eff_dstate_o <= hbic_pkg::DSTATE_D0;
      dual_master_en_o <= 1'b1;
      imm_decode_pm_o <= 1'b0;
      pm_busy_o <= 1'b0;
    end else if (ce_i) begin
      eff_dstate_o <= next_dstate;
      // one function in D3 and the other not
      dual_master_en_o <= !(((f0_dstate_i == hbic_pkg::DSTATE_D3) ^ (f1_dstate_i == hbic_pkg::DSTATE_D3))
        && bus_control_main[hbic_pkg::B_DUAL_GATE]);
      imm_decode_pm_o <= bus_control_main[hbic_pkg::B_IMM_EN] && !bus_control_main[hbic_pkg::B_IMM_DIS];
      pm_busy_o <= pm_busy_i && bus_control_main[hbic_pkg::B_PWR_BUSY];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      io_en_o <= 1'b1;
      mem_en_o <= 1'b1;
      bm_en_o <= 1'b1;
      int_en_o <= 1'b1;
    end else if (ce_i) begin
      // I/O gating applies only in ACPI mode
      io_en_o <= !(low_power && bus_control_main[hbic_pkg::B_PMI_IO] && !bus_control_secondary[hbic_pkg::S_APM]);
      mem_en_o <= !(low_power && bus_control_main[hbic_pkg::B_PMI_MEM]);
      bm_en_o <= !(low_power && bus_control_main[hbic_pkg::B_PMI_BM]);
      int_en_o <= !(low_power && bus_control_main[hbic_pkg::B_PMI_INT]);
    end
  end

  AST_PM_BUSY_BLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !bus_control_main[hbic_pkg::B_PWR_BUSY] |=> !pm_busy_o)
    else $error("power busy driven while blocked");
  AST_MEM_GATE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && low_power && bus_control_main[hbic_pkg::B_PMI_MEM] |=> !mem_en_o)
    else $error("memory cycles not gated in low power");

  ////////////////////////////////////////////////////////////////////////////////
  // busy and coherency timeouts
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy_cnt <= 6'h0;
      backbone_busy_o <= 1'b0;
    end else if (ce_i) begin
      if (!backbone_busy_i) begin
        busy_cnt <= 6'h0;
      end else if (busy_cnt != BUSY_LIMIT) begin
        busy_cnt <= busy_cnt + 6'h1;
      end
      backbone_busy_o <= backbone_busy_i
        && !(bus_control_main[hbic_pkg::B_BUSY_IGN] && busy_cnt == BUSY_LIMIT);
    end
  end

  AST_BUSY_IGNORED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && bus_control_main[hbic_pkg::B_BUSY_IGN] && busy_cnt == BUSY_LIMIT && backbone_busy_i
    |=> !backbone_busy_o) else $error("backbone busy honoured past 32 cycles");

  // a wait or lock that persists is dropped only after the long counter
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wait_cnt <= '0;
      lock_cnt <= '0;
      coh_wait_o <= 1'b0;
      coh_lock_o <= 1'b0;
    end else if (ce_i) begin
      if (!coh_wait_i) begin
        wait_cnt <= '0;
      end else if (wait_cnt != COH_LIMIT) begin
        wait_cnt <= wait_cnt + COH_W'(1);
      end
      if (!coh_lock_i) begin
        lock_cnt <= '0;
      end else if (lock_cnt != COH_LIMIT) begin
        lock_cnt <= lock_cnt + COH_W'(1);
      end
      coh_wait_o <= coh_wait_i && !(bus_control_main[hbic_pkg::B_COH_IGN] && wait_cnt == COH_LIMIT);
      coh_lock_o <= coh_lock_i && !(bus_control_main[hbic_pkg::B_LOCK_REL] && lock_cnt == COH_LIMIT);
    end
  end

  AST_LOCK_RELEASE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && coh_lock_i && lock_cnt != COH_LIMIT |=> coh_lock_o)
    else $error("coherency lock released before counter expiry");

  ////////////////////////////////////////////////////////////////////////////////
  // host path read delay and memory clock gating
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dly_cnt <= 8'h0;
      hdp_rd_allow_o <= 1'b1;
    end else if (ce_i) begin
      if (hdp_wr_i && bus_control_secondary[hbic_pkg::S_DLY_EN]) begin
        dly_cnt <= bus_control_secondary[hbic_pkg::S_DLY_LO +: 8];
      end else if (dly_cnt != 8'h0) begin
        dly_cnt <= dly_cnt - 8'h1;
      end
      hdp_rd_allow_o <= !(hdp_wr_i && bus_control_secondary[hbic_pkg::S_DLY_EN])
        && (dly_cnt <= 8'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      idle_cnt <= 8'h0;
      mclk_en_o <= 1'b1;
    end else if (ce_i) begin
      if (mem_active_i) begin
        idle_cnt <= 8'h0;
        mclk_en_o <= 1'b1;
      end else if (idle_cnt != bus_control_secondary[hbic_pkg::S_MCLK_LO +: 8]) begin
        idle_cnt <= idle_cnt + 8'h1;
      end else begin
        mclk_en_o <= 1'b0;
      end
    end
  end

  AST_MCLK_ON_ACTIVE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && mem_active_i |=> mclk_en_o && idle_cnt == 8'h0)
    else $error("memory clock off while active");

  ////////////////////////////////////////////////////////////////////////////////
  // static controls driven from register fields
  for (genvar w = 0; w < hbic_pkg::N_WM; w++) begin : g_wm
    localparam int unsigned LO = (w == 0) ? hbic_pkg::T_WM0_LO : (w == 1) ? hbic_pkg::T_WM1_LO
      : (w == 2) ? hbic_pkg::T_WM2_LO : hbic_pkg::T_WM3_LO;
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        fifo_slots_o[3*w +: 3] <= 3'h4;
      end else if (ce_i) begin
        fifo_slots_o[3*w +: 3] <= {1'b0, target_side_control[LO +: 2]} + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      coh_check_en_o <= 5'h1f;
      gfx_mc_master_en_o <= 1'b1;
      aud_mc_master_en_o <= 1'b1;
      register_read_wait_o <= 1'b0;
      multi_read_allow_o <= 1'b0;
      nonposted_wait_skip_o <= 1'b0;
      wide_write_en_o <= 1'b1;
      perf0_clk_sel_o <= 2'h0;
      perf1_clk_sel_o <= 2'h0;
    end else if (ce_i) begin
      coh_check_en_o <= ~bus_control_main[hbic_pkg::B_COH_DIS_LO +: 5];
      gfx_mc_master_en_o <= !bus_control_secondary[hbic_pkg::S_GFX_MB];
      aud_mc_master_en_o <= !bus_control_secondary[hbic_pkg::S_AUD_MB];
      register_read_wait_o <= target_side_control[hbic_pkg::T_RD_WAIT];
      multi_read_allow_o <= target_side_control[hbic_pkg::T_MULTI_RD];
      nonposted_wait_skip_o <= target_side_control[hbic_pkg::T_NP_SKIP];
      wide_write_en_o <= !target_side_control[hbic_pkg::T_WIDE_BLK];
      perf0_clk_sel_o <= target_side_control[hbic_pkg::T_PERF0_LO +: 2];
      perf1_clk_sel_o <= target_side_control[hbic_pkg::T_PERF1_LO +: 2];
    end
  end

  AST_COH_DISABLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i ##1 ce_i |-> coh_check_en_o == ~$past(bus_control_main[hbic_pkg::B_COH_DIS_LO +: 5]))
    else $error("coherency check enables do not follow disable bits");
endmodule

/* File: rtl/hbic_pkg.sv */
// Purpose: shared constants for the host bus interface control bank
// Assumes: byte addresses on the register port, 32-bit registers
// Notes: reset images include the reserved and spare bits
package hbic_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] OFF_BUS_MAIN = 16'h0030;
  localparam logic [15:0] OFF_BUS_SEC = 16'h0034;
  localparam logic [15:0] OFF_TGT = 16'h180c;

  localparam logic [31:0] RST_BUS_MAIN = 32'h6fc04000;
  localparam logic [31:0] RST_BUS_SEC = 32'hff070132;
  localparam logic [31:0] RST_TGT = 32'h0c1ffff0;
  // read-only status positions are not stored
  localparam logic [31:0] RO_BUS_MAIN = 32'h00020000;
  localparam logic [31:0] RO_BUS_SEC = 32'h00006000;

  // bus_control_main fields
  localparam int unsigned B_PMI_IO = 0;
  localparam int unsigned B_PMI_MEM = 1;
  localparam int unsigned B_PMI_BM = 2;
  localparam int unsigned B_PMI_INT = 3;
  localparam int unsigned B_IMM_DIS = 4;
  localparam int unsigned B_PWR_BUSY = 5;
  localparam int unsigned B_COH_IGN = 6;
  localparam int unsigned B_BUSY_IGN = 7;
  localparam int unsigned B_COH_DIS_LO = 8;
  localparam int unsigned B_MF_PICK = 13;
  localparam int unsigned B_GFX_BLOCK = 14;
  localparam int unsigned B_DUAL_GATE = 16;
  localparam int unsigned B_MST_BUSY = 17;
  localparam int unsigned B_REARM = 20;
  localparam int unsigned B_SINGLE_RD = 21;
  localparam int unsigned B_SYNC_LO = 22;
  localparam int unsigned B_LOCK_REL = 28;
  localparam int unsigned B_IMM_EN = 29;
  localparam int unsigned B_IMM_EN_RB = 30;
  localparam int unsigned B_IMM_DIS_RB = 31;

  // bus_control_secondary fields
  localparam int unsigned S_DLY_LO = 0;
  localparam int unsigned S_DLY_EN = 8;
  localparam int unsigned S_APM = 10;
  localparam int unsigned S_GFX_MB = 11;
  localparam int unsigned S_AUD_MB = 12;
  localparam int unsigned S_GFX_INT = 13;
  localparam int unsigned S_AUD_INT = 14;
  localparam int unsigned S_MCLK_LO = 16;

  // target_side_control fields
  localparam int unsigned T_NP_SKIP = 1;
  localparam int unsigned T_WIDE_BLK = 2;
  localparam int unsigned T_MULTI_RD = 24;
  localparam int unsigned T_RD_WAIT = 25;
  localparam int unsigned T_PERF0_LO = 28;
  localparam int unsigned T_PERF1_LO = 30;
  localparam int unsigned T_WM0_LO = 14;
  localparam int unsigned T_WM1_LO = 16;
  localparam int unsigned T_WM2_LO = 18;
  localparam int unsigned T_WM3_LO = 26;

  localparam int unsigned N_SYNC = 5;
  localparam int unsigned N_WM = 4;
  localparam int unsigned BUSY_IGN_CYC = 32;
  localparam int unsigned MAX_RD_MULTI = 4;
  localparam int unsigned MAX_RD_ONE = 1;
  localparam logic [1:0] DSTATE_D0 = 2'h0;
  localparam logic [1:0] DSTATE_D3 = 2'h3;
endpackage

/* File: rtl/hbic_sync.sv */
// Purpose: crossing stage with two- or three-flop depth picked at run time
// Assumes: d_i is from another clock domain; dbl_i is from clk_i logic
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module hbic_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic dbl_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // short mode trades metastability margin for one cycle of latency
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q_o <= 1'b0;
    end else if (ce_i) begin
      if (!dbl_i) begin
        q_o <= s2;
      end else if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule

/* File: verif/hbic_cpl_model.sv */
// Purpose: far-side completer for granted master reads
// Assumes: grant_i is the one-cycle grant pulse of the bank
// Notes: one completion per cycle that release_i is high while a granted read is pending
`timescale 1ns/1ps
module hbic_cpl_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic grant_i,
  input wire logic release_i,
  output logic cpl_o
);
  logic [3:0] pend;
  // no kinder than a real client: never completes an ungranted read
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend <= 4'h0;
      cpl_o <= 1'b0;
    end else begin
      cpl_o <= release_i && (pend != 4'h0);
      pend <= pend + {3'h0, grant_i} - {3'h0, release_i && (pend != 4'h0)};
    end
  end
endmodule

/* File: verif/host_bus_iface_control_bench.sv */
// Purpose: register-level regression of the host bus interface control bank
// Assumes: one clock; strobe register port
// Notes: outputs sampled 1 ns after an edge so registered updates have landed
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module host_bus_iface_control_bench;
  logic clk_i, reset_n_i, ce_i, reg_wr_i, reg_rd_i, mst_rd_req_i, mst_rd_cpl_i, msi_event_i;
  logic backbone_busy_i, coh_wait_i, coh_lock_i, pm_busy_i, hdp_wr_i, mem_active_i, gfx_int_i, aud_int_i;
  logic [hbic_pkg::ADDR_W-1:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, mst_rd_data_o, m;
  logic [4:0] xdom_i, xdom_o, coh_check_en_o;
  logic [1:0] f0_dstate_i, f1_dstate_i, eff_dstate_o, perf0_clk_sel_o, perf1_clk_sel_o;
  logic [11:0] fifo_slots_o;
  logic reg_rvalid_o, mst_rd_grant_o, mst_rd_abort_o, msi_send_o, dual_master_en_o, backbone_busy_o;
  logic coh_wait_o, coh_lock_o, imm_decode_pm_o, pm_busy_o, io_en_o, mem_en_o, bm_en_o, int_en_o;
  logic hdp_rd_allow_o, mclk_en_o, gfx_mc_master_en_o, aud_mc_master_en_o, register_read_wait_o;
  logic multi_read_allow_o, nonposted_wait_skip_o, wide_write_en_o, rel;
  int errors = 0;
  int checks_done = 0;
  // short coherency count keeps the run brief
  hbic_ctrl #(.COH_TIMEOUT(40)) i_dut (.*);
  hbic_cpl_model i_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .grant_i(mst_rd_grant_o), .release_i(rel),
    .cpl_o(mst_rd_cpl_i));
////////////////////////////////////////
  task tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    cyc(2);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid_o)
    `CHK("rdata", e, reg_rdata_o)
  endtask
  task mreq(input logic g, input logic ab);
    @(posedge clk_i);
    mst_rd_req_i <= 1'b1;
    @(posedge clk_i);
    mst_rd_req_i <= 1'b0;
    #1;
    `CHK("grant", g, mst_rd_grant_o)
    `CHK("abort", ab, mst_rd_abort_o)
  endtask
  task msi(input logic e);
    @(posedge clk_i);
    msi_event_i <= 1'b1;
    @(posedge clk_i);
    msi_event_i <= 1'b0;
    #1;
    `CHK("msi", e, msi_send_o)
  endtask
  task drain(input int n);
    @(posedge clk_i);
    rel <= 1'b1;
    repeat (n) @(posedge clk_i);
    rel <= 1'b0;
    cyc(3);
  endtask
////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    cyc(20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    {reg_wr_i, reg_rd_i, mst_rd_req_i, msi_event_i, hdp_wr_i, rel, reset_n_i} = '0;
    {coh_wait_i, coh_lock_i, mem_active_i, aud_int_i, reg_addr_i, reg_wdata_i} = '0;
    {ce_i, gfx_int_i, backbone_busy_i, pm_busy_i} = '1;
    {f0_dstate_i, f1_dstate_i} = '0;
    xdom_i = 5'h1f;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    cyc(20);
    `CHK("slots", 12'h924, fifo_slots_o)
    `CHK("mclk", 1'b0, mclk_en_o)
    `CHK("xdom", 5'h1f, xdom_o)
    `CHK("bbusy", 1'b1, backbone_busy_o)
    `CHK("pmbusy", 1'b0, pm_busy_o)
    rd(16'h0030, hbic_pkg::RST_BUS_MAIN);
    rd(16'h0034, hbic_pkg::RST_BUS_SEC | 32'h2000);
    rd(16'h180c, hbic_pkg::RST_TGT);
    rd(16'h0040, 32'h0);
    mreq(1'b0, 1'b1);
    `CHK("abdata", 32'hffffffff, mst_rd_data_o)
    $display("test reset and abort done");
    msi(1'b1);
    msi(1'b0);
    m = hbic_pkg::RST_BUS_MAIN;
    wr(16'h0030, m);
    m = m | 32'h100000;
    wr(16'h0030, m);
    msi(1'b1);
    $display("test msi done");
    m = m & ~32'h4000;
    wr(16'h0030, m);
    repeat (4) mreq(1'b1, 1'b0);
    mreq(1'b0, 1'b0);
    rd(16'h0030, m | 32'h20000);
    drain(1);
    mreq(1'b1, 1'b0);
    drain(6);
    m = m | 32'h200000;
    wr(16'h0030, m);
    mreq(1'b1, 1'b0);
    mreq(1'b0, 1'b0);
    drain(2);
    $display("test outstanding done");
    f0_dstate_i <= 2'h1;
    f1_dstate_i <= 2'h3;
    m = m | 32'h1522;
    wr(16'h0030, m);
    `CHK("eff", 2'h3, eff_dstate_o)
    `CHK("dual", 1'b1, dual_master_en_o)
    `CHK("pmbusy", 1'b1, pm_busy_o)
    `CHK("memen", 1'b0, mem_en_o)
    `CHK("coh", 5'h0a, coh_check_en_o)
    m = m | 32'h12080;
    wr(16'h0030, m);
    `CHK("eff", 2'h1, eff_dstate_o)
    `CHK("dual", 1'b0, dual_master_en_o)
    cyc(40);
    `CHK("bbusy", 1'b0, backbone_busy_o)
    rd(16'h0030, m | 32'h10);
    `CHK("immdec", 1'b1, imm_decode_pm_o)
    `CHK("ioen", 1'b1, io_en_o)
    m = (m | 32'h1000000d) & ~32'h400000;
    wr(16'h0030, m);
    `CHK("ioen", 1'b0, io_en_o)
    `CHK("bmen", 1'b0, bm_en_o)
    `CHK("inten", 1'b0, int_en_o)
    // short crossing on bit 0 lands one cycle before the others
    @(posedge clk_i);
    {coh_wait_i, coh_lock_i, xdom_i} <= 7'h60;
    cyc(4);
    `CHK("xdom", 5'h1e, xdom_o)
    cyc(1);
    `CHK("xdom", 5'h00, xdom_o)
    cyc(35);
    `CHK("cohwait", 1'b1, coh_wait_o)
    `CHK("cohlock", 1'b1, coh_lock_o)
    cyc(1);
    `CHK("cohwait", 1'b1, coh_wait_o)
    `CHK("cohlock", 1'b0, coh_lock_o)
    m = m | 32'h40;
    wr(16'h0030, m);
    `CHK("cohwait", 1'b0, coh_wait_o)
    $display("test power done");
    m = (hbic_pkg::RST_BUS_SEC & ~32'hff) | 32'h1c05;
    wr(16'h0034, m);
    `CHK("ioen", 1'b1, io_en_o)
    `CHK("gfxen", 1'b0, gfx_mc_master_en_o)
    `CHK("auden", 1'b0, aud_mc_master_en_o)
    rd(16'h0034, m | 32'h2000);
    @(posedge clk_i);
    hdp_wr_i <= 1'b1;
    @(posedge clk_i);
    hdp_wr_i <= 1'b0;
    cyc(1);
    `CHK("rdallow", 1'b0, hdp_rd_allow_o)
    cyc(3);
    `CHK("rdallow", 1'b0, hdp_rd_allow_o)
    cyc(1);
    `CHK("rdallow", 1'b1, hdp_rd_allow_o)
    @(posedge clk_i);
    mem_active_i <= 1'b1;
    @(posedge clk_i);
    mem_active_i <= 1'b0;
    cyc(7);
    `CHK("mclk", 1'b1, mclk_en_o)
    cyc(1);
    `CHK("mclk", 1'b0, mclk_en_o)
    $display("test secondary done");
    for (int k = 0; k < 4; k++) begin
      m = (hbic_pkg::RST_TGT & ~32'hf000c000) | 32'h0300000e | (k << 14) | (k << 28) | ((3 - k) << 30);
      wr(16'h180c, m);
      rd(16'h180c, m);
      `CHK("perf0", k[1:0], perf0_clk_sel_o)
      `CHK("perf1", 2'(3 - k), perf1_clk_sel_o)
      `CHK("slot0", 3'(k + 1), fifo_slots_o[2:0])
    end
    `CHK("npskip", 1'b1, nonposted_wait_skip_o)
    `CHK("wide", 1'b0, wide_write_en_o)
    `CHK("multi", 1'b1, multi_read_allow_o)
    `CHK("rdwait", 1'b1, register_read_wait_o)
    // a write while the clock enable is low must not land
    ce_i <= 1'b0;
    wr(16'h180c, 32'h0);
    ce_i <= 1'b1;
    rd(16'h180c, m);
    $display("test target done");
    tally_and_finish();
  end
endmodule
